// ===== src/alarm_clc_regs.sv
`timescale 1ns/1ns
// Summary of operation
// R1 - Clamp flag reported at alarm bit 2
// R2 - Clamp flag set by clamp threshold crossing
// R3 - Reading alarm state clears latched flags
// R4 - Clamp flag sets only when unmasked
// R5 - Undervoltage flag reported at alarm bit 0
// R6 - Undervoltage flag from fault compare, masked
// R7 - Alarm state at 0x1E, writes ignored
// R8 - Comparator compensation field bits 5:3
// R9 - Zero field means no pre-emphasis
// R10 - Enabled alarm latches open-drain alarm pin
// R11 - Mask register at 0x1D, host written
// R12 - Reserved bits read zero, ignore writes
module alarm_clc_regs #(
  parameter int CHANNELS = 2 // Channels sharing the block
) (
  input wire logic CORE_CLK, // 100 MHz core clock
  input wire logic RESETN, // Async reset, active low
  input wire logic SCLK, // Serial clock pin
  input wire logic CS_N, // Serial chip select pin, active low
  input wire logic SDI, // Serial data in pin
  input wire logic [0:0] CH_SEL, // Channel addressed by the host
  input wire alarm_clc_pkg::detect_s [CHANNELS-1:0] DETECT, // Comparators
  output logic SDO, // Serial data out
  output logic ALARM_N_O, // Alarm pin output level (always low)
  output logic ALARM_N_OE, // Alarm pin drive enable
  output logic [2:0] DIFF_COMP_STRENGTH, // Comparator pre-emphasis
  output logic DIFF_COMP_EN, // Comparator pre-emphasis active
  output logic [2:0] DRV_COMP_CH0, // Driver compensation channel 0
  output logic [2:0] DRV_COMP_CH1 // Driver compensation channel 1
);
  // Pin synchronisers, two stages each
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [0:0] ch_s1_q;
  logic [0:0] ch_s2_q;
  logic [1:0] det_s1_q [CHANNELS];
  logic [1:0] det_s2_q [CHANNELS];

  logic [15:0] mask_q [CHANNELS]; // Alarm mask per channel
  logic [CHANNELS-1:0] clamp_flag_q; // Sticky clamp flags
  logic [CHANNELS-1:0] uv_flag_q; // Sticky undervoltage flags
  logic [CHANNELS-1:0] clr_ch; // Read-clear strobe per channel
  logic [2:0] diff_comp_q; // Comparator compensation field
  logic [2:0] drv_comp_q [CHANNELS]; // Driver compensation field
  logic alarm_q; // Latched alarm pin state
  logic [15:0] rd_word; // Word returned to the host
  logic rd_start; // Read address decoded
  logic [6:0] rd_addr; // Address of a read in progress
  alarm_clc_pkg::access_s acc; // Completed access

  // Pins cross from outside the core clock domain
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1_q <= 3'h2;
      pin_s2_q <= 3'h2;
      ch_s1_q <= 1'h0;
      ch_s2_q <= 1'h0;
    end else begin
      pin_s1_q <= {SCLK, CS_N, SDI};
      pin_s2_q <= pin_s1_q;
      ch_s1_q <= CH_SEL;
      ch_s2_q <= ch_s1_q;
    end
  end

  serial_frame u_frame (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .sclk_sync(pin_s2_q[2]),
    .cs_n_sync(pin_s2_q[1]),
    .sdi_sync(pin_s2_q[0]),
    .rd_data(rd_word),
    .sdo(SDO),
    .rd_start(rd_start),
    .acc(acc)
  );

  // Address of a read is complete when the read flag arrives
  assign rd_addr = acc.addr;

  // Read mux; unmapped addresses and reserved bits return zero
  always_comb begin
    rd_word = 16'h0000;
    unique case (rd_addr)
      alarm_clc_pkg::ADDR_ALARM_STATE: begin
        rd_word[alarm_clc_pkg::CLAMP_FLAG_BIT] =
          clamp_flag_q[ch_s2_q]; // [R1]
        rd_word[alarm_clc_pkg::UV_FLAG_BIT] = uv_flag_q[ch_s2_q]; // [R5]
      end
      alarm_clc_pkg::ADDR_ALARM_MASK: begin
        rd_word[alarm_clc_pkg::CLAMP_MASK_BIT] =
          mask_q[ch_s2_q][alarm_clc_pkg::CLAMP_MASK_BIT];
        rd_word[alarm_clc_pkg::VF_MASK_BIT] =
          mask_q[ch_s2_q][alarm_clc_pkg::VF_MASK_BIT];
      end
      alarm_clc_pkg::ADDR_CLC_CTRL: begin
        rd_word[15:13] = drv_comp_q[ch_s2_q]; // [R12]
        if (ch_s2_q == 1'b0) begin
          rd_word[5:3] = diff_comp_q; // [R8]
        end
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // Only the mask and compensation registers accept writes
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < CHANNELS; i++) begin
        mask_q[i] <= alarm_clc_pkg::MASK_RESET;
        drv_comp_q[i] <= alarm_clc_pkg::DRV_COMP_RESET;
      end
      diff_comp_q <= alarm_clc_pkg::DIFF_COMP_RESET; // [R8]
    end else if (acc.wr) begin
      // Writes to the alarm state address fall through unused [R7]
      if (acc.addr == alarm_clc_pkg::ADDR_ALARM_MASK) begin
        // Only the two mask bits are kept [R11] [R12]
        mask_q[ch_s2_q] <= acc.data & 16'h0005;
      end
      if (acc.addr == alarm_clc_pkg::ADDR_CLC_CTRL) begin
        drv_comp_q[ch_s2_q] <= acc.data[15:13];
        if (ch_s2_q == 1'b0) begin
          diff_comp_q <= acc.data[5:3]; // [R8]
        end
      end
    end
  end

  // Read-clear fires at frame end so the word already shifted out
  assign clr_ch = (acc.rd_done &&
    acc.addr == alarm_clc_pkg::ADDR_ALARM_STATE) ?
    (CHANNELS'(1) << ch_s2_q) : '0; // [R3]

  // Detector inputs, flags per channel; set beats read-clear
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          det_s1_q[c] <= 2'h0;
          det_s2_q[c] <= 2'h0;
        end else begin
          det_s1_q[c] <= {DETECT[c].clamp_hit, DETECT[c].uv_hit};
          det_s2_q[c] <= det_s1_q[c];
        end
      end

      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          clamp_flag_q[c] <= 1'b0;
        end else if (det_s2_q[c][1] &&
          !mask_q[c][alarm_clc_pkg::CLAMP_MASK_BIT]) begin
          clamp_flag_q[c] <= 1'b1; // [R2] [R4]
        end else if (clr_ch[c]) begin
          clamp_flag_q[c] <= 1'b0; // [R3]
        end
      end

      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          uv_flag_q[c] <= 1'b0;
        end else if (det_s2_q[c][0] &&
          !mask_q[c][alarm_clc_pkg::VF_MASK_BIT]) begin
          uv_flag_q[c] <= 1'b1; // [R6]
        end else if (clr_ch[c]) begin
          uv_flag_q[c] <= 1'b0; // [R3]
        end
      end
    end
  endgenerate

  // Alarm pin latches on any flag; stays until reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      alarm_q <= 1'b0;
    end else if (|clamp_flag_q || |uv_flag_q) begin
      alarm_q <= 1'b1; // [R10]
    end
  end

  // Open drain: drive low only, release otherwise
  assign ALARM_N_O = 1'b0;
  assign ALARM_N_OE = alarm_q; // [R10]

  // Compensation outputs to the analog blocks
  assign DIFF_COMP_STRENGTH = diff_comp_q; // [R9]
  assign DIFF_COMP_EN = (diff_comp_q != alarm_clc_pkg::COMP_OFF); // [R9]
  assign DRV_COMP_CH0 = drv_comp_q[0];
  assign DRV_COMP_CH1 = drv_comp_q[CHANNELS-1];

  // Unmasked clamp event must reach the flag three cycles after the pin
  a_clamp_flag_set: assert property (@(posedge CORE_CLK) // [R4]
    disable iff (!RESETN)
    det_s2_q[0][1] && !mask_q[0][alarm_clc_pkg::CLAMP_MASK_BIT]
    |=> clamp_flag_q[0])
    else $error("clamp flag not set by unmasked event");

  a_uv_masked_hold: assert property (@(posedge CORE_CLK) // [R6]
    disable iff (!RESETN)
    !uv_flag_q[0] && mask_q[0][alarm_clc_pkg::VF_MASK_BIT]
    |=> !uv_flag_q[0])
    else $error("masked undervoltage flag set");

  a_read_clears: assert property (@(posedge CORE_CLK) // [R3]
    disable iff (!RESETN)
    clr_ch[0] && !det_s2_q[0][1] |=> !clamp_flag_q[0])
    else $error("alarm read did not clear flag");

  a_alarm_latch: assert property (@(posedge CORE_CLK) // [R10]
    disable iff (!RESETN)
    (clamp_flag_q[0] || uv_flag_q[0]) |=> ALARM_N_OE [*3])
    else $error("alarm pin not latched");

  a_state_no_write: assert property (@(posedge CORE_CLK) // [R7]
    disable iff (!RESETN)
    acc.wr && acc.addr == alarm_clc_pkg::ADDR_ALARM_STATE
    |=> $stable(diff_comp_q) && $stable(mask_q[0]))
    else $error("write to alarm state changed a register");

  a_comp_enable: assert property (@(posedge CORE_CLK) // [R9]
    disable iff (!RESETN)
    DIFF_COMP_EN == (DIFF_COMP_STRENGTH != 3'h0))
    else $error("pre-emphasis enable disagrees with field");

  a_comp_write: assert property (@(posedge CORE_CLK) // [R8]
    disable iff (!RESETN)
    acc.wr && acc.addr == alarm_clc_pkg::ADDR_CLC_CTRL && !ch_s2_q[0]
    |=> diff_comp_q == $past(acc.data[5:3]))
    else $error("compensation field not written");

  a_mask_reserved: assert property (@(posedge CORE_CLK) // [R12]
    disable iff (!RESETN)
    (mask_q[0] & 16'hFFFA) == 16'h0000)
    else $error("reserved mask bits held a value");

  // Open-drain level never goes high; only the enable moves
  a_pin_level_low: assert property (@(posedge CORE_CLK) // [R10]
    disable iff (!RESETN)
    ALARM_N_O == 1'b0)
    else $error("alarm pin level not low");

  // Once driven, the alarm pin stays driven until reset
  a_alarm_stays: assert property (@(posedge CORE_CLK) // [R10]
    disable iff (!RESETN)
    ALARM_N_OE |=> ALARM_N_OE)
    else $error("alarm pin released without reset");

  // Any latched flag on either channel drives the pin next cycle
  a_flag_feeds_pin: assert property (@(posedge CORE_CLK) // [R10]
    disable iff (!RESETN)
    (|clamp_flag_q || |uv_flag_q) |=> ALARM_N_OE)
    else $error("flag did not drive alarm pin");

  // Unmasked undervoltage event reaches the flag
  a_uv_flag_set: assert property (@(posedge CORE_CLK) // [R6]
    disable iff (!RESETN)
    det_s2_q[0][0] && !mask_q[0][alarm_clc_pkg::VF_MASK_BIT]
    |=> uv_flag_q[0])
    else $error("undervoltage flag not set");

  // Channel 1 flags follow the same rules as channel 0
  a_ch1_clamp_set: assert property (@(posedge CORE_CLK) // [R2]
    disable iff (!RESETN)
    det_s2_q[1][1] && !mask_q[1][alarm_clc_pkg::CLAMP_MASK_BIT]
    |=> clamp_flag_q[1])
    else $error("channel 1 clamp flag not set");

  a_ch1_uv_set: assert property (@(posedge CORE_CLK) // [R6]
    disable iff (!RESETN)
    det_s2_q[1][0] && !mask_q[1][alarm_clc_pkg::VF_MASK_BIT]
    |=> uv_flag_q[1])
    else $error("channel 1 undervoltage flag not set");

  // A masked clamp alarm never latches
  a_clamp_masked: assert property (@(posedge CORE_CLK) // [R4]
    disable iff (!RESETN)
    !clamp_flag_q[0] && mask_q[0][alarm_clc_pkg::CLAMP_MASK_BIT]
    |=> !clamp_flag_q[0])
    else $error("masked clamp flag set");

  // Read-clear also empties the undervoltage flag
  a_uv_read_clears: assert property (@(posedge CORE_CLK) // [R3]
    disable iff (!RESETN)
    clr_ch[0] && !det_s2_q[0][0] |=> !uv_flag_q[0])
    else $error("alarm read did not clear undervoltage flag");

  // Alarm word carries only the two flag bits
  a_state_reserved: assert property (@(posedge CORE_CLK) // [R12]
    disable iff (!RESETN)
    rd_start && rd_addr == alarm_clc_pkg::ADDR_ALARM_STATE
    |-> (rd_word & 16'hFFFA) == 16'h0000)
    else $error("alarm word reserved bits not zero");

  // Comparator field only moves on a write to its address
  a_comp_hold: assert property (@(posedge CORE_CLK) // [R8]
    disable iff (!RESETN)
    !(acc.wr && acc.addr == alarm_clc_pkg::ADDR_CLC_CTRL)
    |=> $stable(diff_comp_q))
    else $error("compensation field changed without write");

  // Mask only moves on a write to the mask address
  a_mask_hold: assert property (@(posedge CORE_CLK) // [R11]
    disable iff (!RESETN)
    !(acc.wr && acc.addr == alarm_clc_pkg::ADDR_ALARM_MASK)
    |=> $stable(mask_q[0]))
    else $error("mask changed without write");

  // Driver field of channel 0 takes the written bits
  a_drv_write: assert property (@(posedge CORE_CLK) // [R12]
    disable iff (!RESETN)
    acc.wr && acc.addr == alarm_clc_pkg::ADDR_CLC_CTRL && !ch_s2_q[0]
    |=> drv_comp_q[0] == $past(acc.data[15:13]))
    else $error("driver field not written");
endmodule

// ===== src/alarm_clc_pkg.sv
package alarm_clc_pkg;
  // Serial register addresses (7-bit address field)
  localparam logic [6:0] ADDR_ALARM_MASK = 7'h1D;
  localparam logic [6:0] ADDR_ALARM_STATE = 7'h1E;
  localparam logic [6:0] ADDR_CLC_CTRL = 7'h1F;
  // Alarm state field positions
  localparam int CLAMP_FLAG_BIT = 2;
  localparam int UV_FLAG_BIT = 0;
  // Alarm mask field positions (1 = alarm disabled)
  localparam int CLAMP_MASK_BIT = 2;
  localparam int VF_MASK_BIT = 0;
  // Compensation control field positions
  localparam int DRV_COMP_LSB = 13;
  localparam int DIFF_COMP_LSB = 3;
  localparam int COMP_W = 3;
  // Reset values
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [2:0] DIFF_COMP_RESET = 3'h0;
  localparam logic [2:0] DRV_COMP_RESET = 3'h0;
  localparam logic [2:0] COMP_OFF = 3'h0;
  // Serial frame: 7 address bits, read flag, 16 data bits
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;

  // Per-channel analog detector inputs
  typedef struct packed {
    logic clamp_hit;
    logic uv_hit;
  } detect_s;

  // Decoded serial access, one cycle wide
  typedef struct packed {
    logic wr;
    logic rd_done;
    logic [6:0] addr;
    logic [15:0] data;
  } access_s;
endpackage

// ===== src/serial_frame.sv
`timescale 1ns/1ns
// Serial slave: samples the frame, shifts read data out
module serial_frame (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic sclk_sync, // Synchronised serial clock
  input wire logic cs_n_sync, // Synchronised chip select, active low
  input wire logic sdi_sync, // Synchronised serial data in
  input wire logic [15:0] rd_data, // Word to shift out on a read
  output logic sdo, // Serial data out
  output logic rd_start, // Pulse: read address decoded
  output alarm_clc_pkg::access_s acc // Decoded access pulses
);
  logic sclk_prev_q; // Previous serial clock level
  logic [4:0] cnt_q; // Bit counter within frame
  logic [23:0] shift_q; // Incoming shift register
  logic [15:0] out_q; // Outgoing shift register
  logic rise; // Serial clock rising edge
  logic fall; // Serial clock falling edge
  logic rd_q; // Frame is a read

  assign rise = sclk_sync & ~sclk_prev_q & ~cs_n_sync;
  assign fall = ~sclk_sync & sclk_prev_q & ~cs_n_sync;

  // Edge history of the serial clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_sync;
    end
  end

  // Bit capture on rising edges; counter restarts when deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      shift_q <= 24'h000000;
      rd_q <= 1'b0;
    end else if (cs_n_sync) begin
      cnt_q <= 5'h00;
      rd_q <= 1'b0;
    end else if (rise) begin
      shift_q <= {shift_q[22:0], sdi_sync};
      if (cnt_q != alarm_clc_pkg::FRAME_LAST) begin
        cnt_q <= cnt_q + 5'h01;
      end
      if (cnt_q == 5'h07) begin
        rd_q <= sdi_sync;
      end
    end
  end

  // Read flag arrives as bit 7; load output word once address known
  assign rd_start = rise && (cnt_q == 5'h07) && sdi_sync;

  // Output shift: change on falling edge so the host samples on rising
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 16'h0000;
      sdo <= 1'b0;
    end else if (rd_start) begin
      out_q <= rd_data;
    end else if (fall && rd_q) begin
      sdo <= out_q[15];
      out_q <= {out_q[14:0], 1'b0};
    end else if (cs_n_sync) begin
      sdo <= 1'b0;
    end
  end

  // Access pulse on the last rising edge of a full frame
  always_comb begin
    acc = '0;
    acc.addr = shift_q[6:0];
    acc.data = {shift_q[14:0], sdi_sync};
    if (rise && cnt_q == alarm_clc_pkg::FRAME_LAST) begin
      acc.addr = shift_q[22:16];
      acc.wr = ~shift_q[15];
      acc.rd_done = shift_q[15];
    end
  end
endmodule

// ===== bench/spi_host_model.sv
`timescale 1ns/1ns
// Host side of the serial bus; frames are started by task calls
module spi_host_model (
  input wire logic clk, // Core clock
  output logic sclk, // Serial clock, still low outside frames
  output logic cs_n, // Chip select, active low
  output logic sdi, // Serial data to the device
  input wire logic sdo // Serial data from the device
);
  // Six core cycles per level leaves room for the pin synchronisers
  localparam int HALF = 6;
  // Idle levels at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // One whole frame: seven address bits, read flag, data word
  task automatic xfer(input logic [6:0] addr, input logic rd,
                      input logic [15:0] wd, output logic [15:0] rdat);
    logic [23:0] frame;
    frame = {addr, rd, wd}; // Data word goes out as given, reserved bits included
    rdat = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    // Data changes while the clock is low, MSB first
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = frame[i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      // Read data is taken at the rising edge
      if (i < 16) begin
        rdat[i] = sdo;
      end
      repeat (HALF) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    sdi = ~sdi; // Released line must not keep the last bit
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// ===== bench/alarm_clc_regs_bench.sv
`timescale 1ns/1ns
// Self-checking bench: model with ints, compared at every read
module alarm_clc_regs_bench;
  logic core_clk; // 100 MHz clock
  logic resetn; // Reset, active low
  logic sclk, cs_n, sdi, sdo; // Serial pins
  logic [0:0] ch_sel; // Addressed channel
  alarm_clc_pkg::detect_s [1:0] det; // Detector levels
  logic alarm_o, alarm_oe; // Alarm pin level and enable
  logic [2:0] diff_str, drv0, drv1; // Compensation outputs
  logic diff_en; // Pre-emphasis active
  int errors, n_tests; // Counters
  int seed = 32'hC21C864A; // Fixed seed
  int flags [2]; // Model latched flags per channel
  int mask [2]; // Model mask per channel
  int comp [2]; // Model compensation word per channel
  logic alarm_exp; // Model alarm latch
  logic [15:0] rd; // Last word read

  alarm_clc_regs #(.CHANNELS(2)) alarm_clc_regs_i (
    .CORE_CLK(core_clk), .RESETN(resetn), .SCLK(sclk), .CS_N(cs_n),
    .SDI(sdi), .CH_SEL(ch_sel), .DETECT(det), .SDO(sdo),
    .ALARM_N_O(alarm_o), .ALARM_N_OE(alarm_oe),
    .DIFF_COMP_STRENGTH(diff_str), .DIFF_COMP_EN(diff_en),
    .DRV_COMP_CH0(drv0), .DRV_COMP_CH1(drv1));
  spi_host_model spi_host_model_i (.clk(core_clk), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  // Clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Word comparison
  task automatic chk_word(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pin comparison
  task automatic chk_pin(input string what, input logic [2:0] exp,
                         input logic [2:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One frame; a read is checked against the model
  task automatic acc(input logic [6:0] a, input int ch, input logic w,
                     input logic [15:0] d);
    logic [15:0] e;
    @(negedge core_clk);
    ch_sel = 1'(ch);
    e = a == 7'h1D ? 16'(mask[ch]) : a == 7'h1E ? 16'(flags[ch]) :
        a == 7'h1F ? 16'(comp[ch]) & (ch == 0 ? 16'hE038 : 16'hE000) :
        16'h0000;
    spi_host_model_i.xfer(a, !w, w ? d : 16'h0000, rd);
    // Model update; writes to the state word change nothing
    if (w && a == 7'h1D) begin
      mask[ch] = int'(d & 16'h0005);
    end
    if (w && a == 7'h1F) begin
      comp[ch] = int'(d);
    end
    if (!w) begin
      chk_word("read word", e, rd);
    end
    if (!w && a == 7'h1E) begin
      flags[ch] = 0;
    end
  endtask
  // Detector pulse; bits are clamp/uv of channel 1 then channel 0
  task automatic pulse(input logic [3:0] ev);
    @(negedge core_clk);
    det = ev;
    repeat (8) @(negedge core_clk);
    det = '0;
    repeat (8) @(negedge core_clk);
    for (int c = 0; c < 2; c++) begin
      if (ev[2*c+1] && !mask[c][2]) begin
        flags[c] |= 4;
        alarm_exp = 1'b1;
      end
      if (ev[2*c] && !mask[c][0]) begin
        flags[c] |= 1;
        alarm_exp = 1'b1;
      end
    end
  endtask
  // Verdict
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog: about 120 frames of ~310 cycles, doubled for margin
  initial begin
    #750000;
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic [15:0] d;
    resetn = 1'b0;
    ch_sel = 1'b0;
    det = '0;
    errors = 0;
    n_tests = 0;
    flags = '{0, 0};
    mask = '{0, 0};
    comp = '{0, 0};
    alarm_exp = 1'b0;
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    // Reset values of every word on both channels
    for (int c = 0; c < 2; c++) begin
      for (int a = 29; a < 32; a++) begin
        acc(7'(a), c, 1'b0, 16'h0000);
      end
    end
    chk_pin("alarm enable", 3'h0, {2'h0, alarm_oe});
    chk_pin("alarm level", 3'h0, {2'h0, alarm_o});
    $display("test reset done");
    // Every comparator code, random driver fields
    for (int k = 0; k < 8; k++) begin
      d = (16'($random(seed)) & 16'hE000) | 16'(k << 3);
      acc(7'h1F, 0, 1'b1, d);
      acc(7'h1F, 1, 1'b1, ~d & 16'hE038);
      chk_pin("diff strength", 3'(k), diff_str);
      chk_pin("diff enable", {2'h0, k != 0}, {2'h0, diff_en});
      chk_pin("drv ch0", d[15:13], drv0);
      chk_pin("drv ch1", ~d[15:13], drv1);
      acc(7'h1F, 0, 1'b0, 16'h0000);
      acc(7'h1F, 1, 1'b0, 16'h0000);
      acc(7'h22, 0, 1'b1, d);
      acc(7'h22, 0, 1'b0, 16'h0000);
    end
    $display("test compensation done");
    // All alarms masked: nothing latches
    acc(7'h1D, 0, 1'b1, 16'h0005);
    acc(7'h1D, 1, 1'b1, 16'h0005);
    pulse(4'hF);
    chk_pin("alarm enable", 3'h0, {2'h0, alarm_oe});
    acc(7'h1E, 0, 1'b0, 16'h0000);
    acc(7'h1E, 1, 1'b0, 16'h0000);
    $display("test masked done");
    // Random masks and events, read clears
    for (int k = 0; k < 8; k++) begin
      acc(7'h1D, 0, 1'b1, 16'($random(seed)) & 16'h0005);
      acc(7'h1D, 1, 1'b1, 16'($random(seed)) & 16'h0005);
      acc(7'h1D, k % 2, 1'b0, 16'h0000);
      pulse(4'($random(seed)));
      acc(7'h1E, 0, 1'b1, 16'h0005);
      chk_pin("alarm enable", {2'h0, alarm_exp}, {2'h0, alarm_oe});
      acc(7'h1E, 0, 1'b0, 16'h0000);
      acc(7'h1E, 0, 1'b0, 16'h0000);
      acc(7'h1E, 1, 1'b0, 16'h0000);
    end
    $display("test alarms done");
    tally_and_finish();
  end
endmodule
